//--- hw/limit_cmp.sv
// Purpose: signed over-limit comparison of one temperature word
// Assumes: two's complement, sign plus seven bits, one degree per step
// Notes:   strictly greater than, equal does not trip
`timescale 1ns/1ps
module limit_cmp (
   input  wire logic [7:0] temp,
   input  wire logic [7:0] limit,
   output logic            over
);
   // two's complement compare
   assign over = $signed(temp) > $signed(limit);
endmodule

//--- hw/sync2.sv
// Purpose: two flip-flop synchroniser for pin inputs
// Assumes: input is asynchronous to pclk
// Notes:   only the second stage may be read by logic
`timescale 1ns/1ps
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         pclk,
   input  wire logic         presetn,
   input  wire logic         ce,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   logic [W-1:0] meta;

   // first stage feeds second stage only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= '0;
         dout <= '0;
      end else if (ce) begin
         meta <= din;
         dout <= meta;
      end
   end
endmodule

//--- hw/temp_alarm.sv
// Purpose: limit registers, alarm pins and serial slave of a two-channel sensor
// Assumes: converter results arrive on pclk with a valid strobe
// Notes:   APB and the serial port read the same register set; serial writes reach only the three limits
//
// Implementation choices: register access over APB and the address map.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// How it works
// [RL1] any temperature above critical limit: critical alarm
// [RL2] channel above own high limit: high alarm
// [RL3] three limit registers, writable and readable back
// [RL4] all limits reset to 127 degrees
// [RL5] two three-level straps give nine addresses
// [RL6] temperatures are sign plus seven bits
// [RL7] serial port releases bus after clock-low timeout
// [RL8] register access accepted at any time
// [RL9] alarm pins open-drain, pulled low while active
module temp_alarm
   import temp_alarm_pkg::*;
#(
   parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        ce,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   input  wire logic [7:0]  local_temp,
   input  wire logic [7:0]  remote_temp,
   input  wire logic        temp_valid,
   input  wire logic        serial_clock_in,
   input  wire logic        serial_data_line_i,
   output logic             serial_data_line_o,
   output logic             serial_data_line_oe,
   input  wire logic [1:0]  addr_strap_low_bit,
   input  wire logic [1:0]  addr_strap_high_bit,
   output logic             critical_alarm_out_o,
   output logic             critical_alarm_out_oe,
   output logic             high_alarm_out_o,
   output logic             high_alarm_out_oe
);
   logic [7:0]       local_reg;
   logic [7:0]       remote_reg;
   logic [7:0]       critical_limit;
   logic [7:0]       high_local;
   logic [7:0]       high_remote;
   logic [IRQ_W-1:0] irq_status;
   logic [IRQ_W-1:0] irq_mask;
   logic [IRQ_W-1:0] irq_events;
   logic [6:0]       slave_addr;
   logic             strap_taken;
   logic [1:0]       strap_wait;
   logic [3:0]       straps_s;
   logic [1:0]       line_s;
   logic             scl_q;
   logic             sda_q;
   logic             scl_rise;
   logic             scl_fall;
   logic             start_c;
   logic             stop_c;
   smb_state_e       state;
   logic [3:0]       bitcnt;
   logic [7:0]       shreg;
   logic [7:0]       ptr;
   logic             first;
   logic             rw;
   logic             mack;
   logic             smb_wr;
   logic [7:0]       smb_wdata;
   logic [TO_W-1:0]  to_cnt;
   logic             timeout_hit;
   logic             over_cl;
   logic             over_cr;
   logic             over_hl;
   logic             over_hr;
   logic             crit_cond;
   logic             apb_setup;
   logic             apb_access;
   logic             apb_wr;
   logic             apb_bad;
   logic [31:0]      smb_rword;

   // register image by word index
   function automatic logic [31:0] reg_value(input logic [2:0] idx);
      logic [31:0] v;
      v = '0;
      if (idx == OFS_LOCAL_TEMP[4:2]) v[7:0] = local_reg;
      else if (idx == OFS_REMOTE_TEMP[4:2]) v[7:0] = remote_reg;
      else if (idx == OFS_CRIT_LIMIT[4:2]) v[7:0] = critical_limit;
      else if (idx == OFS_HIGH_LOCAL[4:2]) v[7:0] = high_local;
      else if (idx == OFS_HIGH_REMOTE[4:2]) v[7:0] = high_remote;
      else if (idx == OFS_IRQ_STATUS[4:2]) v[IRQ_W-1:0] = irq_status;
      else if (idx == OFS_IRQ_MASK[4:2]) v[IRQ_W-1:0] = irq_mask;
      else v[6:0] = slave_addr;
      return v;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   sync2 #(.W(4)) u_sync_strap (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .din     ({addr_strap_high_bit, addr_strap_low_bit}),
      .dout    (straps_s)
   );
   sync2 #(.W(2)) u_sync_line (
      .pclk    (pclk),
      .presetn (presetn),
      .ce      (ce),
      .din     ({serial_clock_in, serial_data_line_i}),
      .dout    (line_s)
   );

   // [RL5] strap address decode
   // straps are caught once after release, so a later wiggle cannot move the address
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         strap_taken <= 1'b0;
         strap_wait  <= 2'h0;
         slave_addr  <= SMB_BASE_ADDR;
      end else if (ce && !strap_taken) begin
         // the synchroniser still shows its reset value for two edges
         if (strap_wait == STRAP_SETTLE) begin
            strap_taken <= 1'b1;
            slave_addr  <= SMB_BASE_ADDR + 7'(3 * (straps_s[3] ? 2 : {1'b0, straps_s[2]}))
                           + 7'(straps_s[1] ? 2 : {1'b0, straps_s[0]});
         end else begin
            strap_wait <= strap_wait + 2'h1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // [RL6] capture signed results
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         local_reg  <= 8'h00;
         remote_reg <= 8'h00;
      end else if (ce && temp_valid) begin
         local_reg  <= local_temp;
         remote_reg <= remote_temp;
      end
   end

   // [RL1] [RL2] channel comparators
   limit_cmp u_cmp_cl (.temp(local_reg),  .limit(critical_limit), .over(over_cl));
   limit_cmp u_cmp_cr (.temp(remote_reg), .limit(critical_limit), .over(over_cr));
   limit_cmp u_cmp_hl (.temp(local_reg),  .limit(high_local),     .over(over_hl));
   limit_cmp u_cmp_hr (.temp(remote_reg), .limit(high_remote),    .over(over_hr));
   assign crit_cond = over_cl | over_cr;

   // [RL9] open-drain alarm pins
   // pins only ever pull low; the released level comes from the pull-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         critical_alarm_out_oe <= 1'b0;
         high_alarm_out_oe     <= 1'b0;
      end else if (ce) begin
         critical_alarm_out_oe <= crit_cond;
         high_alarm_out_oe     <= over_hl | over_hr;
      end
   end
   assign critical_alarm_out_o = 1'b0;
   assign high_alarm_out_o     = 1'b0;
   assign serial_data_line_o   = 1'b0;

   ////////////////////////////////////////////////////////////////////////////
   // apb decode, zero wait states
   assign apb_setup  = ce & psel & ~penable;
   assign apb_access = ce & psel & penable;
   assign apb_bad    = (paddr[7:5] != 3'h0) || (paddr[1:0] != 2'h0);
   assign apb_wr     = apb_access & pwrite & ~apb_bad;
   // [RL8] never busy
   assign pready     = ce;
   assign pslverr    = psel & penable & apb_bad;

   // read data taken in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0000_0000;
      else if (apb_setup) prdata <= apb_bad ? 32'h0000_0000 : reg_value(paddr[4:2]);
   end

   // [RL3] [RL4] limit registers
   // both ports may write; an apb write in the same cycle wins
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         critical_limit <= LIMIT_RESET;
         high_local     <= LIMIT_RESET;
         high_remote    <= LIMIT_RESET;
      end else if (ce) begin
         if (apb_wr && paddr == OFS_CRIT_LIMIT) critical_limit <= pwdata[7:0];
         else if (smb_wr && ptr == {2'b00, OFS_CRIT_LIMIT[7:2]}) critical_limit <= smb_wdata;
         if (apb_wr && paddr == OFS_HIGH_LOCAL) high_local <= pwdata[7:0];
         else if (smb_wr && ptr == {2'b00, OFS_HIGH_LOCAL[7:2]}) high_local <= smb_wdata;
         if (apb_wr && paddr == OFS_HIGH_REMOTE) high_remote <= pwdata[7:0];
         else if (smb_wr && ptr == {2'b00, OFS_HIGH_REMOTE[7:2]}) high_remote <= smb_wdata;
      end
   end

   // sticky events, set beats a write-one clear
   assign irq_events = {timeout_hit, over_hr & ~high_alarm_out_oe,
                        over_hl & ~high_alarm_out_oe, crit_cond & ~critical_alarm_out_oe};
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= IRQ_RESET;
         irq_mask   <= IRQ_RESET;
      end else if (ce) begin
         if (apb_wr && paddr == OFS_IRQ_STATUS)
            irq_status <= (irq_status & ~pwdata[IRQ_W-1:0]) | irq_events;
         else
            irq_status <= irq_status | irq_events;
         if (apb_wr && paddr == OFS_IRQ_MASK) irq_mask <= pwdata[IRQ_W-1:0];
      end
   end
   assign irq = |(irq_status & irq_mask);

   ////////////////////////////////////////////////////////////////////////////
   // serial line edges from the synchronised copies
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else if (ce) begin
         scl_q <= line_s[1];
         sda_q <= line_s[0];
      end
   end
   assign scl_rise = line_s[1] & ~scl_q;
   assign scl_fall = ~line_s[1] & scl_q;
   assign start_c  = line_s[1] & scl_q & sda_q & ~line_s[0];
   assign stop_c   = line_s[1] & scl_q & ~sda_q & line_s[0];
   assign smb_rword = ptr[7:3] == 5'h00 ? reg_value(ptr[2:0]) : 32'h0000_0000;

   // [RL7] clock-low watchdog
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) to_cnt <= '0;
      else if (ce) begin
         if (state == S_IDLE || line_s[1] || timeout_hit) to_cnt <= '0;
         else to_cnt <= to_cnt + 1'b1;
      end
   end
   assign timeout_hit = (to_cnt == TO_W'(TIMEOUT_CYCLES - 1)) && !line_s[1] && state != S_IDLE;

   // [RL8] serial slave engine, independent of conversions
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state               <= S_IDLE;
         bitcnt              <= 4'h0;
         shreg               <= 8'h00;
         ptr                 <= 8'h00;
         first               <= 1'b0;
         rw                  <= 1'b0;
         mack                <= 1'b0;
         smb_wr              <= 1'b0;
         smb_wdata           <= 8'h00;
         serial_data_line_oe <= 1'b0;
      end else if (ce) begin
         smb_wr <= 1'b0;
         if (timeout_hit) begin
            // [RL7] release the data line
            state               <= S_IDLE;
            serial_data_line_oe <= 1'b0;
         end else if (start_c) begin
            state               <= S_ADDR;
            bitcnt              <= 4'h0;
            first               <= 1'b1;
            serial_data_line_oe <= 1'b0;
         end else if (stop_c) begin
            state               <= S_IDLE;
            serial_data_line_oe <= 1'b0;
         end else begin
            case (state)
               S_ADDR, S_WRB: begin
                  if (scl_rise) begin
                     shreg  <= {shreg[6:0], line_s[0]};
                     bitcnt <= bitcnt + 4'h1;
                  end else if (scl_fall && bitcnt == 4'h8) begin
                     bitcnt <= 4'h0;
                     if (state == S_ADDR) begin
                        if (shreg[7:1] == slave_addr) begin
                           state               <= S_AACK;
                           rw                  <= shreg[0];
                           serial_data_line_oe <= 1'b1;
                        end else begin
                           state <= S_IDLE;
                        end
                     end else begin
                        // first data byte sets the pointer
                        state               <= S_WACK;
                        serial_data_line_oe <= 1'b1;
                        first               <= 1'b0;
                        if (first) ptr <= shreg;
                        else begin
                           smb_wr    <= 1'b1;
                           smb_wdata <= shreg;
                        end
                     end
                  end
               end
               S_AACK: begin
                  if (scl_fall) begin
                     if (rw) begin
                        state               <= S_RDB;
                        shreg               <= smb_rword[7:0];
                        serial_data_line_oe <= ~smb_rword[7];
                     end else begin
                        state               <= S_WRB;
                        serial_data_line_oe <= 1'b0;
                     end
                  end
               end
               S_WACK: begin
                  if (scl_fall) begin
                     state               <= S_WRB;
                     serial_data_line_oe <= 1'b0;
                  end
               end
               S_RDB: begin
                  if (scl_rise) bitcnt <= bitcnt + 4'h1;
                  else if (scl_fall) begin
                     if (bitcnt == 4'h8) begin
                        state               <= S_RACK;
                        bitcnt              <= 4'h0;
                        serial_data_line_oe <= 1'b0;
                     end else begin
                        shreg               <= {shreg[6:0], 1'b0};
                        serial_data_line_oe <= ~shreg[6];
                     end
                  end
               end
               S_RACK: begin
                  // master ack repeats the same register
                  if (scl_rise) mack <= ~line_s[0];
                  else if (scl_fall) begin
                     if (mack) begin
                        state               <= S_RDB;
                        shreg               <= smb_rword[7:0];
                        serial_data_line_oe <= ~smb_rword[7];
                     end else begin
                        state <= S_IDLE;
                     end
                  end
               end
               default: state <= S_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // checks
   property p_crit;
      @(posedge pclk) disable iff (!presetn)
      ce && crit_cond |=> critical_alarm_out_oe;
   endproperty
   a_crit: assert property (p_crit) else $error("critical alarm not raised"); // [RL1]

   property p_high;
      @(posedge pclk) disable iff (!presetn)
      ce && $signed(remote_reg) > $signed(high_remote) |=> high_alarm_out_oe;
   endproperty
   a_high: assert property (p_high) else $error("high alarm not raised"); // [RL2]

   property p_rdback;
      @(posedge pclk) disable iff (!presetn)
      apb_wr && paddr == OFS_HIGH_LOCAL ##2 ce && psel && !penable && paddr == OFS_HIGH_LOCAL
      |=> prdata[7:0] == $past(pwdata[7:0], 3);
   endproperty
   a_rdback: assert property (p_rdback) else $error("limit readback wrong"); // [RL3]

   property p_reset_lim;
      @(posedge pclk) $rose(presetn) |-> critical_limit == 8'h7F && high_remote == 8'h7F;
   endproperty
   a_reset_lim: assert property (p_reset_lim) else $error("limit not 127 after reset"); // [RL4]

   property p_addr;
      @(posedge pclk) disable iff (!presetn)
      strap_taken && $past(strap_taken)
      |-> slave_addr >= SMB_BASE_ADDR && slave_addr <= SMB_BASE_ADDR + 7'h08 && $stable(slave_addr);
   endproperty
   a_addr: assert property (p_addr) else $error("slave address out of range"); // [RL5]

   property p_temp;
      @(posedge pclk) disable iff (!presetn)
      ce && temp_valid |=> local_reg == $past(local_temp) && remote_reg == $past(remote_temp);
   endproperty
   a_temp: assert property (p_temp) else $error("temperature not captured"); // [RL6]

   property p_timeout;
      @(posedge pclk) disable iff (!presetn)
      ce && timeout_hit |=> state == S_IDLE && !serial_data_line_oe && irq_status[IRQ_TIMEOUT];
   endproperty
   a_timeout: assert property (p_timeout) else $error("bus not released on timeout"); // [RL7]

   property p_ready;
      @(posedge pclk) disable iff (!presetn)
      psel && penable && ce |-> pready;
   endproperty
   a_ready: assert property (p_ready) else $error("access stalled"); // [RL8]

   property p_od;
      @(posedge pclk) disable iff (!presetn)
      ce && !crit_cond |=> !critical_alarm_out_oe && !critical_alarm_out_o && !high_alarm_out_o;
   endproperty
   a_od: assert property (p_od) else $error("alarm pin drives wrongly"); // [RL9]
endmodule

//--- hw/temp_alarm_pkg.sv
// Purpose: shared constants and types of the temperature alarm block
// Assumes: 40 MHz pclk, 8-bit signed temperature words
// Notes:   register offsets are byte addresses on the APB port
package temp_alarm_pkg;
   // clock and serial bus timeout
   localparam int CLK_PERIOD_NSEC = 25;
   localparam int TIMEOUT_MS      = 25;
   localparam int TIMEOUT_CYC     = TIMEOUT_MS * 1_000_000 / CLK_PERIOD_NSEC;
   localparam int TO_W          = 24;
   // limit value after power-up, 127 degrees
   localparam logic [7:0] LIMIT_RESET = 8'h7F;
   // register byte offsets
   localparam logic [7:0] OFS_LOCAL_TEMP  = 8'h00;
   localparam logic [7:0] OFS_REMOTE_TEMP = 8'h04;
   localparam logic [7:0] OFS_CRIT_LIMIT  = 8'h08;
   localparam logic [7:0] OFS_HIGH_LOCAL  = 8'h0C;
   localparam logic [7:0] OFS_HIGH_REMOTE = 8'h10;
   localparam logic [7:0] OFS_IRQ_STATUS  = 8'h14;
   localparam logic [7:0] OFS_IRQ_MASK    = 8'h18;
   localparam logic [7:0] OFS_SLAVE_ADDR  = 8'h1C;
   // interrupt status bit positions
   localparam int IRQ_CRIT      = 0;
   localparam int IRQ_HIGH_LOC  = 1;
   localparam int IRQ_HIGH_REM  = 2;
   localparam int IRQ_TIMEOUT   = 3;
   localparam int IRQ_W         = 4;
   localparam logic [3:0] IRQ_RESET = 4'h0;
   // three-level strap codes
   localparam logic [1:0] STRAP_LOW  = 2'b00;
   localparam logic [1:0] STRAP_HIGH = 2'b01;
   localparam logic [1:0] STRAP_OPEN = 2'b10;
   localparam logic [6:0] SMB_BASE_ADDR = 7'h18;
   // edges to wait after release so the strap synchroniser has settled
   localparam logic [1:0] STRAP_SETTLE  = 2'h3;
   // serial slave states
   typedef enum logic [6:0] {
      S_IDLE = 7'b000_0001,
      S_ADDR = 7'b000_0010,
      S_AACK = 7'b000_0100,
      S_WRB  = 7'b000_1000,
      S_WACK = 7'b001_0000,
      S_RDB  = 7'b010_0000,
      S_RACK = 7'b100_0000
   } smb_state_e;
endpackage

//--- tb/smb_host_model.sv
// Purpose: serial bus host model driving clock and data toward the sensor
// Assumes: pull-up on both lines, one bit time is 8 pclk (200 ns)
// Notes:   the clock stands high between frames, it never runs free
`timescale 1ns/1ps
module smb_host_model (
   input  wire logic pclk,
   input  wire logic sda,
   output logic      scl,
   output logic      sda_low
);
   initial begin
      scl = 1'b1;
      sda_low = 1'b0;
   end
   task automatic ticks(input int n);
      repeat (n) @(posedge pclk);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // frames at any time
   // start: data falls while the clock is high
   task automatic start();
      sda_low <= 1'b1;
      ticks(4);
      scl <= 1'b0;
      ticks(4);
   endtask
   // stop: data rises while the clock is high
   task automatic stop();
      sda_low <= 1'b1;
      ticks(4);
      scl <= 1'b1;
      ticks(4);
      sda_low <= 1'b0;
      ticks(4);
   endtask
   // msb first, then the ninth clock samples the acknowledge
   task automatic wbyte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         sda_low <= ~b[i];
         ticks(4);
         scl <= 1'b1;
         ticks(4);
         scl <= 1'b0;
      end
      sda_low <= 1'b0;
      ticks(4);
      scl <= 1'b1;
      ticks(2);
      ack = (sda === 1'b0);
      ticks(2);
      scl <= 1'b0;
      ticks(4);
   endtask
   // read with data released; mack high means the host acknowledges
   task automatic rbyte(input logic mack, output logic [7:0] b);
      sda_low <= 1'b0;
      for (int i = 7; i >= 0; i--) begin
         ticks(4);
         scl <= 1'b1;
         ticks(2);
         b[i] = sda;
         ticks(2);
         scl <= 1'b0;
      end
      sda_low <= mack;
      ticks(4);
      scl <= 1'b1;
      ticks(4);
      scl <= 1'b0;
      ticks(4);
   endtask
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench of the temperature alarm block
// Assumes: 40 MHz pclk, timeout shortened to 200 cycles
// Notes:   data line level is worked out from both open-drain drivers
`timescale 1ns/1ps
module tb_top;
   import temp_alarm_pkg::*;
   typedef struct packed {
      logic        wr;
      logic [7:0]  addr;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic        err;
   } row_s;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready, pslverr, irq, temp_valid = 1'b0;
   logic [7:0]  local_temp = 8'h00;
   logic [7:0]  remote_temp = 8'h00;
   logic        scl, host_low, sda_o, sda_oe, crit_o, crit_oe, high_o, high_oe;
   wire  logic  sda = ~(host_low | sda_oe);
   int          n_fail = 0;
   int          checks = 0;
   logic [31:0] rd;
   logic        er, ack;
   logic [7:0]  sb;
   row_s        rows [14];
   always #12.5 pclk = ~pclk;
   // straps: high pin open, low pin high, so address 0x18 + 6 + 1
   temp_alarm #(.TIMEOUT_CYCLES(200)) i_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .local_temp(local_temp),
      .remote_temp(remote_temp), .temp_valid(temp_valid), .serial_clock_in(scl),
      .serial_data_line_i(sda), .serial_data_line_o(sda_o), .serial_data_line_oe(sda_oe),
      .addr_strap_low_bit(STRAP_HIGH), .addr_strap_high_bit(STRAP_OPEN),
      .critical_alarm_out_o(crit_o), .critical_alarm_out_oe(crit_oe),
      .high_alarm_out_o(high_o), .high_alarm_out_oe(high_oe));
   smb_host_model i_host (.pclk(pclk), .sda(sda), .scl(scl), .sda_low(host_low));
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // apb transfer, held until pready is seen high at a rising edge
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      if (n == 50) begin
         n_fail++;
         test_done();
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic temps(input logic [7:0] l, input logic [7:0] r);
      @(posedge pclk);
      local_temp <= l;
      remote_temp <= r;
      temp_valid <= 1'b1;
      @(posedge pclk);
      temp_valid <= 1'b0;
      i_host.ticks(4);
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      rows = '{'{0, 8'h08, 0, 32'h7F, 0}, '{0, 8'h0C, 0, 32'h7F, 0}, '{0, 8'h10, 0, 32'h7F, 0},
               '{0, 8'h14, 0, 32'h0, 0}, '{0, 8'h18, 0, 32'h0, 0}, '{0, 8'h1C, 0, 32'h1F, 0},
               '{1, 8'h1C, 32'h5, 0, 0}, '{0, 8'h1C, 0, 32'h1F, 0}, '{1, 8'h08, 32'h55, 0, 0},
               '{0, 8'h08, 0, 32'h55, 0}, '{0, 8'h20, 0, 32'h0, 1}, '{1, 8'h0C, 32'h3C, 0, 0},
               '{0, 8'h0C, 0, 32'h3C, 0}, '{1, 8'h10, 32'h3D, 0, 0}};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      i_host.ticks(6);
      foreach (rows[i]) begin
         apb(rows[i].wr, rows[i].addr, rows[i].wdata, rd, er);
         if (!rows[i].wr) check(rd, rows[i].exp);
         check({31'h0, er}, {31'h0, rows[i].err});
      end
      // serial write of the critical limit, then readback both ways
      i_host.start();
      i_host.wbyte({7'h1F, 1'b0}, ack);
      check({31'h0, ack}, 32'h1);
      i_host.wbyte(8'h02, ack);
      i_host.wbyte(8'h64, ack);
      i_host.stop();
      apb(1'b0, 8'h08, 0, rd, er);
      check(rd, 32'h64);
      i_host.start();
      i_host.wbyte({7'h1F, 1'b1}, ack);
      i_host.rbyte(1'b0, sb);
      i_host.stop();
      check({24'h0, sb}, 32'h64);
      // another address on the bus is not acknowledged
      i_host.start();
      i_host.wbyte({7'h18, 1'b0}, ack);
      i_host.stop();
      check({31'h0, ack}, 32'h0);
      // high alarm per channel, equal does not trip
      temps(8'h3D, 8'h3D);
      check({30'h0, high_oe, crit_oe}, 32'h2);
      check({30'h0, high_o, crit_o}, 32'h0);
      apb(1'b0, 8'h14, 0, rd, er);
      check(rd, 32'h2);
      check({31'h0, irq}, 32'h0);
      // irq settles at the same edge the write lands; checked one edge later
      apb(1'b1, 8'h18, 32'h2, rd, er);
      i_host.ticks(1);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, 8'h14, 32'h2, rd, er);
      i_host.ticks(1);
      check({31'h0, irq}, 32'h0);
      // signed compare: -5 above a -10 limit, -128 below all
      apb(1'b1, 8'h08, 32'hF6, rd, er);
      temps(8'hFB, 8'h80);
      check({30'h0, high_oe, crit_oe}, 32'h1);
      apb(1'b0, 8'h14, 0, rd, er);
      check(rd, 32'h1);
      temps(8'h80, 8'h80);
      check({30'h0, high_oe, crit_oe}, 32'h0);
      // clock held low mid-frame: the slave lets go
      i_host.start();
      i_host.wbyte({7'h1F, 1'b0}, ack);
      i_host.ticks(260);
      apb(1'b0, 8'h14, 0, rd, er);
      check(rd[3:0], 4'h9);
      check({31'h0, sda_oe}, 32'h0);
      i_host.stop();
      test_done();
   end
endmodule
